// ---- rtl/lps_serializer.sv ----
// pixel serializer: captures 28-bit pixel words on a chosen pixel clock
// edge and sends them as four 7-slot serial lanes plus a forwarded clock
// assumes the pixel clock, its data and the control pins are asynchronous
// to CLK and that the pixel period spans at least seven CLK cycles
//
// Overview of operation
// - all four data lane pairs float while power-down input is low
// - forwarded clock pair also floats while power-down input is low
// - power-down low clears every register; high runs normally
// - capture on rising pixel clock edge if select high, falling if low
// - in 18-bit colour lane three stays driven; all pairs share one enable
// - four 7-bit shift registers load all 28 bits at each word start, from the word buffer or as idle zeros when it is empty
// - bit rate is seven per pixel period, one 7-bit slice per lane
// - forwarded clock matches pixel clock rate and aligns with data
`timescale 1ns/1ps
`default_nettype none
module lps_serializer
    import lps_pkg::*;
(
    input wire logic CLK,                      // 25 MHz system clock
    input wire logic RESETN,                   // asynchronous reset, active low
    input wire logic POWER_DOWN_N,             // shutdown when low
    input wire logic CAPTURE_EDGE_SELECT,      // high rising, low falling
    input wire logic PIXEL_CLOCK_IN,           // incoming pixel clock
    input wire logic [WORD_W-1:0] PIXEL_BITS,  // parallel pixel word
    output logic LANE0_POS,                    // lane 0 true side
    output logic LANE0_NEG,                    // lane 0 complement side
    output logic LANE0_OE_N,                   // lane 0 drive enable, low drives
    output logic LANE1_POS,                    // lane 1 true side
    output logic LANE1_NEG,                    // lane 1 complement side
    output logic LANE1_OE_N,                   // lane 1 drive enable, low drives
    output logic LANE2_POS,                    // lane 2 true side
    output logic LANE2_NEG,                    // lane 2 complement side
    output logic LANE2_OE_N,                   // lane 2 drive enable, low drives
    output logic LANE3_POS,                    // lane 3 true side
    output logic LANE3_NEG,                    // lane 3 complement side
    output logic LANE3_OE_N,                   // lane 3 drive enable, low drives
    output logic FWD_CLOCK_POS,                // forwarded clock true side
    output logic FWD_CLOCK_NEG,                // forwarded clock complement side
    output logic FWD_CLOCK_OE_N,               // forwarded clock enable, low drives
    output logic CAPTURE_OVERRUN               // pulse: word dropped, buffer full
);
    // internal reset, asserted by either pin, released on CLK
    logic arst_n;
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // pin synchronisers
    logic [2:0] pclk_sync_reg;
    logic [2:0] sel_sync_reg;
    logic [WORD_W-1:0] data_s0_reg;
    logic [WORD_W-1:0] data_s1_reg;
    logic [WORD_W-1:0] data_s2_reg;
    logic pclk_level_reg;
    logic sel_level_reg;

    // period measurement
    logic [PERIOD_W-1:0] cnt_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic [PERIOD_W-1:0] meas;
    logic edge_seen_reg;
    logic link_live_reg;
    logic link_live_next;

    // bit timing and slots
    logic [PERIOD_W:0] acc_reg;
    logic [PERIOD_W:0] acc_sum;
    logic [PERIOD_W:0] acc_next;
    logic [2:0] slot_reg;
    logic [2:0] slot_next;
    logic tick;
    logic word_start;

    // capture and buffering
    logic pclk_agree;
    logic pclk_change;
    logic pclk_rise;
    logic pclk_fall;
    logic capture_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [WORD_W-1:0] fifo_word;
    logic [WORD_W-1:0] load_word;

    // output stage
    logic [SLOTS-1:0] shift_reg [LANES];
    logic [LANES-1:0] lane_bit_reg;
    logic [LANES-1:0] lane_neg_reg;
    logic fwd_bit_reg;
    logic fwd_neg_reg;
    logic fwd_level;
    logic oe_n_reg;
    logic overrun_reg;

    // reset combine: shutdown asserts at once, release waits two edges
    assign arst_n = RESETN && POWER_DOWN_N;
    assign rst_n = rst_sync_reg[1];

    // reset release synchroniser
    always_ff @(posedge CLK or negedge arst_n) begin
        if (!arst_n) rst_sync_reg <= 2'h0;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // three-stage sampling of pixel clock, select and data
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pclk_sync_reg <= SYNC_RESET;
            sel_sync_reg <= SYNC_RESET;
            data_s0_reg <= WORD_IDLE;
            data_s1_reg <= WORD_IDLE;
            data_s2_reg <= WORD_IDLE;
        end else begin
            pclk_sync_reg <= {pclk_sync_reg[1:0], PIXEL_CLOCK_IN};
            sel_sync_reg <= {sel_sync_reg[1:0], CAPTURE_EDGE_SELECT};
            data_s0_reg <= PIXEL_BITS;
            data_s1_reg <= data_s0_reg;
            data_s2_reg <= data_s1_reg;
        end
    end

    // edge decode once the second and third stages agree
    assign pclk_agree = (pclk_sync_reg[1] == pclk_sync_reg[2]);
    assign pclk_change = pclk_agree && (pclk_sync_reg[2] != pclk_level_reg);
    assign pclk_rise = pclk_change && pclk_sync_reg[2];
    assign pclk_fall = pclk_change && !pclk_sync_reg[2];
    assign capture_edge = sel_level_reg ? pclk_rise : pclk_fall;

    // filtered levels of pixel clock and edge select
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pclk_level_reg <= 1'b0;
            sel_level_reg <= 1'b0;
        end else begin
            if (pclk_agree) pclk_level_reg <= pclk_sync_reg[2];
            if (sel_sync_reg[1] == sel_sync_reg[2]) sel_level_reg <= sel_sync_reg[2];
        end
    end

    // period between selected edges; a stopped clock halts the link
    assign meas = (cnt_reg == PERIOD_MAX) ? PERIOD_MAX : cnt_reg + 1'b1;
    assign link_live_next = capture_edge ? (edge_seen_reg && meas >= PERIOD_MIN) :
                            (cnt_reg == PERIOD_MAX) ? 1'b0 : link_live_reg;

    // period counter and lock state
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            period_reg <= PERIOD_MAX;
            edge_seen_reg <= 1'b0;
            link_live_reg <= 1'b0;
        end else begin
            cnt_reg <= capture_edge ? '0 : meas;
            if (capture_edge) period_reg <= meas;
            if (capture_edge) edge_seen_reg <= 1'b1;
            link_live_reg <= link_live_next;
        end
    end

    // seven ticks per measured period by a remainder accumulator
    assign acc_sum = acc_reg + BIT_STEP;
    assign tick = link_live_reg && (acc_sum >= {1'b0, period_reg});
    assign acc_next = !link_live_reg ? '0 : tick ? acc_sum - {1'b0, period_reg} : acc_sum;
    assign slot_next = (slot_reg == SLOT_LAST) ? SLOT_FIRST : slot_reg + 1'b1;
    assign word_start = tick && (slot_reg == SLOT_LAST);
    assign fwd_level = FWD_PATTERN[SLOT_LAST - slot_next];

    // slot sequencing
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
            slot_reg <= SLOT_LAST;
        end else begin
            acc_reg <= acc_next;
            if (!link_live_reg) slot_reg <= SLOT_LAST;
            else if (tick) slot_reg <= slot_next;
        end
    end

    // word buffer between capture and the serial engine
    assign fifo_pop = word_start;
    assign load_word = fifo_out_valid ? fifo_word : WORD_IDLE;

    lps_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_n(rst_n),
        .in_valid(capture_edge),
        .in_ready(fifo_in_ready),
        .in_data(data_s2_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_word)
    );

    // one independent shift register per lane
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
                shift_reg[l] <= '0;
                lane_bit_reg[l] <= 1'b0;
                lane_neg_reg[l] <= 1'b1;
            end else if (!link_live_reg) begin
                shift_reg[l] <= '0;
                lane_bit_reg[l] <= 1'b0;
                lane_neg_reg[l] <= 1'b1;
            end else if (word_start) begin
                shift_reg[l] <= load_word[l*SLOTS +: SLOTS];
                lane_bit_reg[l] <= load_word[l*SLOTS + SLOTS - 1];
                lane_neg_reg[l] <= !load_word[l*SLOTS + SLOTS - 1];
            end else if (tick) begin
                shift_reg[l] <= {shift_reg[l][SLOTS-2:0], 1'b0};
                lane_bit_reg[l] <= shift_reg[l][SLOTS-2];
                lane_neg_reg[l] <= !shift_reg[l][SLOTS-2];
            end
        end
    end

    // forwarded clock, enables and overrun flag
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fwd_bit_reg <= 1'b0;
            fwd_neg_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            overrun_reg <= 1'b0;
        end else begin
            if (!link_live_reg) begin
                fwd_bit_reg <= 1'b0;
                fwd_neg_reg <= 1'b1;
            end else if (tick) begin
                fwd_bit_reg <= fwd_level;
                fwd_neg_reg <= !fwd_level;
            end
            oe_n_reg <= 1'b0;
            overrun_reg <= capture_edge && !fifo_in_ready;
        end
    end

    // pin mapping, each pair and its enable
    assign LANE0_POS = lane_bit_reg[0];
    assign LANE0_NEG = lane_neg_reg[0];
    assign LANE0_OE_N = oe_n_reg;
    assign LANE1_POS = lane_bit_reg[1];
    assign LANE1_NEG = lane_neg_reg[1];
    assign LANE1_OE_N = oe_n_reg;
    assign LANE2_POS = lane_bit_reg[2];
    assign LANE2_NEG = lane_neg_reg[2];
    assign LANE2_OE_N = oe_n_reg;
    assign LANE3_POS = lane_bit_reg[3];
    assign LANE3_NEG = lane_neg_reg[3];
    assign LANE3_OE_N = oe_n_reg;
    assign FWD_CLOCK_POS = fwd_bit_reg;
    assign FWD_CLOCK_NEG = fwd_neg_reg;
    assign FWD_CLOCK_OE_N = oe_n_reg;
    assign CAPTURE_OVERRUN = overrun_reg;
endmodule // lps_serializer
`default_nettype wire

// ---- rtl/lps_pkg.sv ----
// constants shared by the pixel serializer and its word buffer
// assumes a single 25 MHz system clock samples every pin of the link
package lps_pkg;
    // clock period of CLK in ns, for reference by timing figures
    localparam int CLK_PERIOD_NS = 40;
    // lane and word geometry
    localparam int LANES = 4;
    localparam int SLOTS = 7;
    localparam int WORD_W = 28;
    localparam int FIFO_DEPTH = 8;
    // pixel period measurement, in CLK cycles
    localparam int PERIOD_W = 10;
    localparam logic [PERIOD_W-1:0] PERIOD_MIN = 10'h007;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = 10'h3FF;
    localparam logic [PERIOD_W:0] BIT_STEP = 11'h007;
    // serial slot numbering
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    // forwarded clock level per slot, slot 0 in bit 6
    localparam logic [6:0] FWD_PATTERN = 7'h63;
    // reset values
    localparam logic [WORD_W-1:0] WORD_IDLE = 28'h0000000;
    localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage : lps_pkg

// ---- rtl/lps_fifo.sv ----
// word buffer with valid and ready on both sides, storage in flip-flops
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module lps_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    input wire logic clk,               // system clock
    input wire logic rst_n,             // asynchronous reset, active low
    input wire logic in_valid,          // write request
    output logic in_ready,              // room for a word
    input wire logic [WIDTH-1:0] in_data, // word written
    output logic out_valid,             // a word is waiting
    input wire logic out_ready,         // reader takes the word
    output logic [WIDTH-1:0] out_data   // oldest word
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] COUNT_FULL = (PTR_W+1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic [PTR_W:0] count_next;
    logic push;
    logic pop;

    // handshake decode
    assign in_ready = (count_reg != COUNT_FULL);
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    assign count_next = count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

    // pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
            count_reg <= count_next;
        end
    end

    // storage, one generate entry per word
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_reg[i] <= '0;
            end else if (push && wr_ptr_reg == PTR_W'(i)) begin
                mem_reg[i] <= in_data;
            end
        end
    end
endmodule // lps_fifo
`default_nettype wire

// ---- bench/lps_serializer_sva.sv ----
// assertions on the serializer pins
// assumes CLK clocks every pin and RESETN resets that domain
`timescale 1ns/1ps
`default_nettype none
module lps_serializer_sva (
    input wire logic CLK, // clock
    input wire logic RESETN, // reset
    input wire logic POWER_DOWN_N, // shutdown
    input wire logic LANE0_POS, // lane 0
    input wire logic LANE1_POS, // lane 1
    input wire logic LANE2_POS, // lane 2
    input wire logic LANE3_POS, // lane 3
    input wire logic LANE0_OE_N, // enable 0
    input wire logic LANE1_OE_N, // enable 1
    input wire logic LANE2_OE_N, // enable 2
    input wire logic LANE3_OE_N, // enable 3
    input wire logic FWD_CLOCK_POS, // clock true
    input wire logic FWD_CLOCK_NEG, // clock inverse
    input wire logic FWD_CLOCK_OE_N, // clock enable
    input wire logic CAPTURE_OVERRUN // drop pulse
);
    // grouped enables and lane bits
    logic [4:0] oe_all;
    logic [3:0] lanes;
    assign oe_all = {FWD_CLOCK_OE_N, LANE3_OE_N, LANE2_OE_N, LANE1_OE_N, LANE0_OE_N};
    assign lanes = {LANE3_POS, LANE2_POS, LANE1_POS, LANE0_POS};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // release from shutdown, and the shortest low run of the clock pattern
    sequence s_release; $rose(POWER_DOWN_N) ##0 POWER_DOWN_N [*5]; endsequence
    sequence s_low3; !FWD_CLOCK_POS [*3]; endsequence
    property p_lanes_float; !POWER_DOWN_N |-> oe_all[3:0] == 4'hF; endproperty
    a_lanes_float: assert property (p_lanes_float) else $error("lane driven");
    property p_fwd_float; !POWER_DOWN_N |-> FWD_CLOCK_OE_N; endproperty
    a_fwd_float: assert property (p_fwd_float) else $error("clock driven");
    property p_cleared; !POWER_DOWN_N |-> lanes == 4'h0 && !FWD_CLOCK_POS && !CAPTURE_OVERRUN; endproperty
    a_cleared: assert property (p_cleared) else $error("not cleared");
    property p_release; s_release |-> oe_all == 5'h00; endproperty
    a_release: assert property (p_release) else $error("no drive after wake");
    property p_stay_on; POWER_DOWN_N && oe_all == 5'h00 |=> oe_all == 5'h00 || !POWER_DOWN_N; endproperty
    a_stay_on: assert property (p_stay_on) else $error("drive dropped");
    property p_same_enable; oe_all == 5'h00 || oe_all == 5'h1F; endproperty
    a_same_enable: assert property (p_same_enable) else $error("enables split");
    property p_fwd_low; $fell(FWD_CLOCK_POS) |-> s_low3; endproperty
    a_fwd_low: assert property (p_fwd_low) else $error("clock low run short");
    property p_fwd_high; $rose(FWD_CLOCK_POS) |-> (FWD_CLOCK_POS || !POWER_DOWN_N) [*2]; endproperty
    a_fwd_high: assert property (p_fwd_high) else $error("clock high run short");
    property p_fwd_pair; FWD_CLOCK_NEG == !FWD_CLOCK_POS; endproperty
    a_fwd_pair: assert property (p_fwd_pair) else $error("clock pair broken");
endmodule // lps_serializer_sva
`default_nettype wire

// ---- bench/lps_rx_model.sv ----
// receiver model: recovers pixel words from the lanes
// assumes seven slots span exactly eight CLK cycles
`timescale 1ns/1ps
`default_nettype none
module lps_rx_model
    import lps_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic [LANES-1:0] lane, // lane true sides
    input wire logic fwd, // forwarded clock
    output logic [WORD_W-1:0] word, // recovered word
    output logic word_ok // pulse: word recovered
);
    logic [44:0] hist;
    logic [6:0] msk, v;
    logic [WORD_W-1:0] acc;
    logic [4:0] d;
    int sel;
    // sample m of a window when sample k is the doubled one
    function automatic logic [4:0] smp(int k, int m);
        return hist[5 * (8 - ((m > k) ? m + 1 : m)) +: 5];
    endfunction
    // at each fall of the forwarded clock, learn the doubled slot, decode slots 2..6,0,1
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist = '0;
            msk = 7'h7F;
            acc = '0;
            word_ok <= 1'b0;
        end else begin
            word_ok <= 1'b0;
            hist = {hist[39:0], fwd, lane};
            if (!hist[4] && hist[9]) begin
                for (int k = 0; k < 7; k++) begin
                    v[k] = hist[5 * (8 - k) +: 5] == hist[5 * (7 - k) +: 5];
                    for (int m = 0; m < 7; m++) begin
                        d = smp(k, m);
                        v[k] = v[k] && (d[4] == (m > 2));
                    end
                end
                if (v != 7'h00) msk = msk & v;
                sel = 0;
                for (int k = 6; k >= 0; k--) if (msk[k]) sel = k;
                for (int m = 0; m < 7; m++) begin
                    if (m == 5) begin
                        word <= acc;
                        word_ok <= $onehot(msk) && v[sel];
                        acc = '0;
                    end
                    d = smp(sel, m);
                    for (int l = 0; l < LANES; l++) acc[l * SLOTS + 6 - (m + 2) % 7] = d[l];
                end
            end
        end
    end
endmodule // lps_rx_model
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: pixel source, receiver model, word comparison
// assumes the package, design and receiver model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lps_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, pd_n = 1'b0, sel = 1'b1, pclk = 1'b0;
    logic run = 1'b0, synced = 1'b0, fpos, fneg, foe, ovr, rx_ok;
    logic [WORD_W-1:0] bits = '0, tie = 28'hFFFFFFF, rx_word;
    logic [WORD_W-1:0] q [$];
    logic [3:0] pos, neg, oe;
    logic [31:0] seed = 32'h3CEF;
    logic [1:0] pdiv = 2'h0;
    int failures = 0, check_count = 0, cycles = 0, hit;
    lps_serializer lps_serializer_inst (.CLK(clk), .RESETN(rst_n), .POWER_DOWN_N(pd_n),
        .CAPTURE_EDGE_SELECT(sel), .PIXEL_CLOCK_IN(pclk), .PIXEL_BITS(bits),
        .LANE0_POS(pos[0]), .LANE0_NEG(neg[0]), .LANE0_OE_N(oe[0]), .LANE1_POS(pos[1]),
        .LANE1_NEG(neg[1]), .LANE1_OE_N(oe[1]), .LANE2_POS(pos[2]), .LANE2_NEG(neg[2]),
        .LANE2_OE_N(oe[2]), .LANE3_POS(pos[3]), .LANE3_NEG(neg[3]), .LANE3_OE_N(oe[3]),
        .FWD_CLOCK_POS(fpos), .FWD_CLOCK_NEG(fneg), .FWD_CLOCK_OE_N(foe), .CAPTURE_OVERRUN(ovr));
    lps_rx_model lps_rx_model_inst (.clk(clk), .rst_n(rst_n && pd_n), .lane(pos), .fwd(fpos),
        .word(rx_word), .word_ok(rx_ok));
    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("FAIL at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #20 clk = ~clk;
    end
    // pixel source, 320 ns period from a CLK divider, still while idle
    always @(posedge clk) begin
        if (!run) begin
            bits <= bits & tie;
        end else begin
            pdiv <= pdiv + 2'h1;
            if (pdiv == 2'h3) begin
                pclk <= !pclk;
                if ((!pclk) == sel) q.push_back(bits);
                else begin
                    seed = xs(seed);
                    bits <= seed[WORD_W-1:0] & tie;
                end
            end
        end
    end
    // watchdog, then every recovered word against the captured queue
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
        if (rx_ok && !synced && rx_word !== '0) begin
            hit = -1;
            foreach (q[i]) if (hit < 0 && q[i] === rx_word) hit = i;
            synced = hit >= 0;
            if (synced) q = q[hit+1:$];
        end else if (rx_ok && synced) begin
            check(rx_word, (q.size() > 0) ? q.pop_front() : '0);
            check(WORD_W'({neg, fneg}), WORD_W'(5'h1F ^ {pos, fpos}));
            check(WORD_W'(ovr), '0);
        end
    end
    // one traffic phase per capture edge and colour depth, shutdown at each end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int ph = 0; ph < 3; ph++) begin
            @(posedge clk);
            tie <= (ph == 2) ? 28'h77CF3DF : 28'hFFFFFFF;
            sel <= ph != 1;
            pd_n <= 1'b1;
            repeat (6) @(posedge clk);
            check(WORD_W'({oe, foe}), '0);
            synced = 1'b0;
            run <= 1'b1;
            repeat (400) @(posedge clk);
            run <= 1'b0;
            repeat (100) @(posedge clk);
            check(WORD_W'({synced, q.size() == 0}), 28'h0000003);
            if (ph == 0) begin
                // pixel clock stopped past the stall limit: link quiet, pins still driven
                repeat (1000) @(posedge clk);
                check(WORD_W'({oe, foe, pos, fpos, neg, fneg}), 28'h000001F);
            end
            pd_n <= 1'b0;
            @(posedge clk);
            @(posedge clk);
            check(WORD_W'({oe, foe, pos, fpos}), 28'h00003E0);
            q.delete();
        end
        report_and_stop();
    end
endmodule // testbench
bind lps_serializer lps_serializer_sva lps_serializer_sva_inst (.CLK(CLK), .RESETN(RESETN),
    .POWER_DOWN_N(POWER_DOWN_N), .LANE0_POS(LANE0_POS), .LANE1_POS(LANE1_POS),
    .LANE2_POS(LANE2_POS), .LANE3_POS(LANE3_POS), .LANE0_OE_N(LANE0_OE_N),
    .LANE1_OE_N(LANE1_OE_N), .LANE2_OE_N(LANE2_OE_N), .LANE3_OE_N(LANE3_OE_N),
    .FWD_CLOCK_POS(FWD_CLOCK_POS), .FWD_CLOCK_NEG(FWD_CLOCK_NEG),
    .FWD_CLOCK_OE_N(FWD_CLOCK_OE_N), .CAPTURE_OVERRUN(CAPTURE_OVERRUN));
`default_nettype wire
